/* File: bridge_decoder_pkg.sv */
package bridge_decoder_pkg;
    // ---------------------------------------------------------------
    // address map
    // ---------------------------------------------------------------
    localparam logic [31:0] BRIDGE_BASE = 32'h4000_0000;
    localparam logic [11:0] BRIDGE_WIN_TAG = 12'h400;   // addr[31:20], 1024 KB window
    localparam int SLOT_SHIFT = 12;                      // 4 KB slots
    localparam int NUM_SLOTS = 129;
    localparam int SLOT_W = 8;
    localparam logic [7:0] ON_PLATFORM_SLOTS = 8'h20;    // 32 slots, 128 KB
    localparam logic [7:0] ORDINARY_SLOTS = 8'h80;       // 32 + 96 slots
    localparam logic [7:0] GPIO_SLOT = 8'h0f;
    localparam logic [7:0] GPIO_ALIAS_SLOT = 8'h80;
    localparam logic [7:0] GPIO_ALIAS_PAGE = 8'hff;      // addr[19:12] of 0x400f_f000
    // one bit per ordinary slot, bit n for slot n
    localparam logic [127:0] POPULATED = 128'h26d8_1cf0_0004_0300_2f8e_0011_0000_8000;
    localparam logic [127:0] NARROW8 = 128'hf9ff_ffff_0004_0000_0002_0000_0000_0000;
    localparam logic [127:0] NARROW16 = 128'h0000_0000_0000_0000_0000_0010_0000_0000;
    // ---------------------------------------------------------------
    // width codes and private bus map
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {W8 = 2'h0, W16 = 2'h1, W32 = 2'h2} width_t;
    localparam logic [31:0] PRIV_BASE = 32'he000_0000;
    localparam logic [31:0] SYSTEM_CONTROL_SPACE_LO = 32'he000_e000;
    localparam logic [31:0] SYSTEM_CONTROL_SPACE_HI = 32'he000_efff;
    localparam logic [31:0] NESTED_IRQ_CONTROLLER_LO = 32'he000_e100;
    localparam logic [31:0] NESTED_IRQ_CONTROLLER_HI = 32'he000_ecff;
    localparam logic [31:0] SCB_LO = 32'he000_ed00;
    localparam logic [31:0] SCB_HI = 32'he000_ed8f;
    localparam logic [31:0] CORE_ROM_SPACE_LO = 32'he00f_f000;
    localparam logic [31:0] CORE_ROM_SPACE_HI = 32'he00f_ffff;
    localparam logic [11:0] PRIV_TAG = 12'he00;
    localparam int ERR_CYCLES = 2;
endpackage : bridge_decoder_pkg

/* File: peripheral_bridge_decoder.sv */
`timescale 1ns/1ns
// Function
// (R1) respond on one crossbar port to window 0x4000_0000..0x400f_ffff
// (R2) first 128 KB: 32 slots of 4 KB, one enable each
// (R3) next 384 KB: 96 more 4 KB slots, one enable each
// (R4) slot 128 at 0x400f_f000 aliases GPIO slot 15
// (R5) GPIO also reached directly by the core without bridge wait states
// (R6) cleared clock gate bit disables that module's slot
// (R7) absent or disabled slot access ends in transfer error
// (R8) unimplemented offset inside a slot ends in transfer error
// (R9) master reads back a written register before dependent actions
// (R10) slots 0-95 and 128 are 32 bit; 49, 82 are 8; 36 is 16
// (R11) slots 96-127 are 8 bit except 121 and 122 at 32
// (R12) slot n based at 0x4000_0000 plus n times 4 KB
// (R13) only listed slots populated; all others unimplemented
// (R14) private region accepts only core accesses
// (R15) control space 0xe000_e000; irq controller e100; control block ed00
// (R16) core rom space 0xe00f_f000..ffff; other private ranges reserved
// (R17) error is two-cycle response with no module enable
// (R18) enables low and no transfers accepted during reset; core_gpio_enable and the private selects do not depend on arst_n
module peripheral_bridge_decoder (
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // crossbar slave port
    input wire logic xbar_sel,
    input wire logic [31:0] xbar_addr,
    input wire logic xbar_from_core,
    output logic xbar_ready,
    output logic xbar_err,
    // per-slot side
    input wire logic [127:0] slot_clk_gate,
    input wire logic [127:0] slot_offset_ok,
    input wire logic [127:0] slot_done,
    output logic [127:0] slot_enable,
    output logic [1:0] slot_width,
    output logic [11:0] slot_offset,
    // core direct GPIO and private bus
    input wire logic core_gpio_sel,
    output logic core_gpio_enable,
    input wire logic priv_sel,
    input wire logic [31:0] priv_addr,
    input wire logic priv_from_core,
    output logic priv_system_control_space_sel,
    output logic priv_nested_irq_controller_sel,
    output logic priv_scb_sel,
    output logic priv_core_rom_space_sel,
    output logic priv_err
);
    import bridge_decoder_pkg::*;

    typedef enum logic [3:0] {
        S_IDLE = 4'b0001, S_ACCESS = 4'b0010, S_ERR1 = 4'b0100, S_ERR2 = 4'b1000
    } state_t;

    // ---------------------------------------------------------------
    // decode helpers
    // ---------------------------------------------------------------
    function automatic logic [7:0] slot_of(input logic [31:0] a);
        if (a[19:12] == GPIO_ALIAS_PAGE) begin
            slot_of = GPIO_SLOT; // (R4)
        end else if (a[19] == 1'b0) begin
            slot_of = a[19:12]; // (R12) (R2) (R3)
        end else begin
            slot_of = 8'hff; // reserved hole above slot 127
        end
    endfunction : slot_of

    function automatic width_t width_of(input logic [7:0] s);
        if (NARROW16[s[6:0]]) begin
            width_of = W16; // (R10)
        end else if (NARROW8[s[6:0]]) begin
            width_of = W8; // (R10) (R11)
        end else begin
            width_of = W32;
        end
    endfunction : width_of

    // ---------------------------------------------------------------
    // transfer decode
    // ---------------------------------------------------------------
    logic in_window;
    logic [7:0] dec_slot;
    logic slot_live;
    assign in_window = (xbar_addr[31:20] == BRIDGE_WIN_TAG); // (R1)
    assign dec_slot = slot_of(xbar_addr);
    // disabled or absent slots are refused before any enable fires
    assign slot_live = (dec_slot < ORDINARY_SLOTS) && POPULATED[dec_slot[6:0]]
                       && slot_clk_gate[dec_slot[6:0]]; // (R13) (R6) (R7)

    state_t state_r, state_nxt;
    logic [127:0] en_r, en_nxt;
    logic [1:0] width_r, width_nxt;
    logic [11:0] off_r, off_nxt;
    logic [6:0] idx_r, idx_nxt;

    // ---------------------------------------------------------------
    // transfer sequencer
    // ---------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        en_nxt = en_r;
        width_nxt = width_r;
        off_nxt = off_r;
        idx_nxt = idx_r;
        unique case (state_r)
            S_IDLE: begin
                if (xbar_sel && in_window) begin
                    if (slot_live && slot_offset_ok[dec_slot[6:0]]) begin
                        state_nxt = S_ACCESS;
                        idx_nxt = dec_slot[6:0];
                        en_nxt = 128'h1 << dec_slot[6:0];
                        width_nxt = width_of(dec_slot);
                        off_nxt = xbar_addr[11:0];
                    end else begin
                        state_nxt = S_ERR1; // (R7) (R8) (R17)
                    end
                end
            end
            S_ACCESS: begin
                if (slot_done[idx_r]) begin
                    state_nxt = S_IDLE;
                    en_nxt = '0;
                end
            end
            S_ERR1: state_nxt = S_ERR2; // (R17)
            S_ERR2: state_nxt = S_IDLE;
        endcase
    end

    // registers only; reset keeps every slot enable low (R18)
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= S_IDLE; // (R18)
            en_r <= '0;
            width_r <= W32;
            off_r <= 12'h000;
            idx_r <= 7'h00;
        end else begin
            state_r <= state_nxt;
            en_r <= en_nxt;
            width_r <= width_nxt;
            off_r <= off_nxt;
            idx_r <= idx_nxt;
        end
    end

    assign slot_enable = en_r; // (R2) (R3)
    assign slot_width = width_r;
    assign slot_offset = off_r;
    // error holds ready low in the first cycle and high in the second
    assign xbar_err = (state_r == S_ERR1) || (state_r == S_ERR2); // (R17)
    assign xbar_ready = ((state_r == S_ACCESS) && slot_done[idx_r])
                        || (state_r == S_ERR2);

    // core direct GPIO path bypasses the sequencer, no wait states
    assign core_gpio_enable = core_gpio_sel && slot_clk_gate[GPIO_SLOT[6:0]]; // (R5)

    // ---------------------------------------------------------------
    // private bus decode
    // ---------------------------------------------------------------
    logic priv_ok;
    assign priv_ok = priv_sel && priv_from_core && (priv_addr[31:20] == PRIV_TAG); // (R14)
    assign priv_system_control_space_sel = priv_ok && (priv_addr >= SYSTEM_CONTROL_SPACE_LO)
                                           && (priv_addr <= SYSTEM_CONTROL_SPACE_HI); // (R15)
    assign priv_nested_irq_controller_sel = priv_ok && (priv_addr >= NESTED_IRQ_CONTROLLER_LO)
                                            && (priv_addr <= NESTED_IRQ_CONTROLLER_HI);
    assign priv_scb_sel = priv_ok && (priv_addr >= SCB_LO) && (priv_addr <= SCB_HI);
    assign priv_core_rom_space_sel = priv_ok && (priv_addr >= CORE_ROM_SPACE_LO)
                                     && (priv_addr <= CORE_ROM_SPACE_HI); // (R16)
    // reserved ranges and non-core masters get an error
    assign priv_err = priv_sel && !priv_system_control_space_sel
                      && !priv_core_rom_space_sel; // (R14) (R16)

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    property p_err_two;
        @(posedge mclk) disable iff (!arst_n)
        (state_r == S_IDLE && xbar_sel && in_window && !slot_live)
            |=> xbar_err && !xbar_ready ##1 xbar_err && xbar_ready;
    endproperty
    a_err_two: assert property (p_err_two) else $error("error response not two cycles"); // (R17)

    property p_no_en_on_err;
        @(posedge mclk) disable iff (!arst_n)
        xbar_err |-> (slot_enable == '0);
    endproperty
    a_no_en_on_err: assert property (p_no_en_on_err) else $error("enable during error"); // (R7)

    property p_gated;
        @(posedge mclk) disable iff (!arst_n)
        (state_r == S_IDLE && xbar_sel && in_window && !slot_clk_gate[dec_slot[6:0]])
            |=> slot_enable == '0;
    endproperty
    a_gated: assert property (p_gated) else $error("gated slot enabled"); // (R6)

    property p_onehot;
        @(posedge mclk) disable iff (!arst_n)
        $onehot0(slot_enable);
    endproperty
    a_onehot: assert property (p_onehot) else $error("multiple slot enables"); // (R2)

    property p_populated;
        @(posedge mclk) disable iff (!arst_n)
        (slot_enable != '0) |-> POPULATED[idx_r] && slot_enable[idx_r];
    endproperty
    a_populated: assert property (p_populated) else $error("empty slot enabled"); // (R13)

    property p_alias;
        @(posedge mclk) disable iff (!arst_n)
        (state_r == S_IDLE && xbar_sel && xbar_addr[31:12] == 20'h400ff && slot_live
         && slot_offset_ok[15]) |=> slot_enable[15] && slot_width == 2'h2;
    endproperty
    a_alias: assert property (p_alias) else $error("gpio alias not routed"); // (R4)

    property p_priv_core;
        @(posedge mclk) disable iff (!arst_n)
        !priv_from_core |-> !(priv_system_control_space_sel || priv_core_rom_space_sel);
    endproperty
    a_priv_core: assert property (p_priv_core) else $error("private bus reached by non-core"); // (R14)

    property p_width;
        @(posedge mclk) disable iff (!arst_n)
        $rose(slot_enable[36]) |-> slot_width == 2'h1;
    endproperty
    a_width: assert property (p_width) else $error("slot 36 width wrong"); // (R10)
endmodule : peripheral_bridge_decoder

/* File: periph_model.sv */
`timescale 1ns/1ns
// ----------------------------------------
// peripheral side of the bridge
// ----------------------------------------
module periph_model (
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // bridge side
    input wire logic [127:0] slot_enable,
    input wire logic [31:0] xbar_addr,
    input wire logic slow,
    output logic [127:0] slot_offset_ok,
    output logic [127:0] slot_done
);
    logic [1:0] wait_r;
    logic [1:0] wait_nxt;
    // only the low 256 bytes of a slot exist, the rest must fault
    assign slot_offset_ok = (xbar_addr[11:8] == 4'h0) ? {128{1'b1}} : '0;
    // done only for enabled slots, so a slot without an enable never completes
    assign slot_done = (!slow || wait_r == 2'h2) ? slot_enable : '0;
    // slow mode holds completion off for two cycles
    always_comb begin
        wait_nxt = 2'h0;
        if (|slot_enable && wait_r != 2'h2) begin
            wait_nxt = wait_r + 2'h1;
        end
    end
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wait_r <= 2'h0;
        end else begin
            wait_r <= wait_nxt;
        end
    end
endmodule : periph_model

/* File: tb_top.sv */
`timescale 1ns/1ns
`define check_eq(n, e, a) begin checks_done++; if ((a) !== (e)) begin bad_count++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module tb_top;
    import bridge_decoder_pkg::*;
    logic mclk, arst_n, xbar_sel, xbar_from_core, xbar_ready, xbar_err, slow;
    logic [31:0] xbar_addr, priv_addr;
    logic [127:0] slot_clk_gate, slot_offset_ok, slot_done, slot_enable;
    logic [1:0] slot_width;
    logic [11:0] slot_offset;
    logic core_gpio_sel, core_gpio_enable, priv_sel, priv_from_core, priv_err;
    logic priv_system_control_space_sel, priv_nested_irq_controller_sel;
    logic priv_scb_sel, priv_core_rom_space_sel;
    int bad_count = 0;
    int checks_done = 0;
    int slots[9] = '{15, 36, 49, 82, 100, 121, 122, 125, 128};
    width_t wids[9] = '{W32, W16, W8, W8, W8, W32, W32, W8, W32};
    logic [31:0] bad_addr[6] = '{32'h4000_0000, 32'h4007_f000, 32'h4008_0000,
        32'h400f_e000, 32'h4003_7800, 32'h4003_7000};
    peripheral_bridge_decoder peripheral_bridge_decoder_inst (
        .mclk(mclk), .arst_n(arst_n),
        .xbar_sel(xbar_sel), .xbar_addr(xbar_addr), .xbar_from_core(xbar_from_core),
        .xbar_ready(xbar_ready), .xbar_err(xbar_err),
        .slot_clk_gate(slot_clk_gate), .slot_offset_ok(slot_offset_ok), .slot_done(slot_done),
        .slot_enable(slot_enable), .slot_width(slot_width), .slot_offset(slot_offset),
        .core_gpio_sel(core_gpio_sel), .core_gpio_enable(core_gpio_enable),
        .priv_sel(priv_sel), .priv_addr(priv_addr), .priv_from_core(priv_from_core),
        .priv_system_control_space_sel(priv_system_control_space_sel),
        .priv_nested_irq_controller_sel(priv_nested_irq_controller_sel),
        .priv_scb_sel(priv_scb_sel), .priv_core_rom_space_sel(priv_core_rom_space_sel),
        .priv_err(priv_err));
    periph_model periph_model_inst (.mclk(mclk), .arst_n(arst_n), .slot_enable(slot_enable),
        .xbar_addr(xbar_addr), .slow(slow), .slot_offset_ok(slot_offset_ok),
        .slot_done(slot_done));
    // ----------------------------------------
    // clock and bus cycle
    // ----------------------------------------
    always #10 mclk = ~mclk;
    // request held until the edge at which ready is seen
    task automatic xact(input logic [31:0] a, output int errs, output logic [127:0] en,
        output logic [1:0] w, output logic [11:0] off);
        errs = 0;
        en = '0;
        @(posedge mclk);
        xbar_sel <= 1'b1;
        xbar_addr <= a;
        for (int n = 0; n < 20; n++) begin
            @(negedge mclk);
            errs += (xbar_err !== 1'b0); // an unknown error flag counts as an error
            if (|slot_enable) begin
                en = slot_enable;
                w = slot_width;
                off = slot_offset;
            end
            if (xbar_ready === 1'b1) break;
        end
        @(posedge mclk);
        xbar_sel <= 1'b0;
    endtask : xact
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_reset;
        repeat (3) begin
            @(negedge mclk);
            `check_eq("rst", {128'h0, 2'h0, W32}, {slot_enable, xbar_ready, xbar_err, slot_width})
        end
        @(posedge mclk);
        arst_n <= 1'b1;
    endtask : t_reset
    // a select outside the window must be ignored
    task t_window;
        @(posedge mclk);
        xbar_sel <= 1'b1;
        xbar_addr <= 32'h4010_0000;
        repeat (3) begin
            @(negedge mclk);
            `check_eq("outside", 3'h0, {xbar_ready, xbar_err, |slot_enable})
        end
        @(posedge mclk);
        xbar_sel <= 1'b0;
    endtask : t_window
    task automatic t_good;
        int e;
        int b;
        logic [127:0] en;
        logic [1:0] w;
        logic [11:0] off;
        logic [31:0] a;
        for (int i = 0; i < 9; i++) begin
            b = (slots[i] == 128) ? 15 : slots[i];
            a = (slots[i] == 128) ? 32'h400f_f004 : 32'h4000_0004 + (b << 12);
            slow <= i[0];
            xact(a, e, en, w, off);
            `check_eq("enable", 128'h1 << b, en)
            `check_eq("width", wids[i], w)
            `check_eq("offset", 12'h004, off)
            `check_eq("good err", 0, e)
            // the master reads the same register back before moving on
            xact(a, e, en, w, off);
            `check_eq("readback", 128'h1 << b, en)
            `check_eq("readback err", 0, e)
        end
    endtask : t_good
    // absent, reserved, bad offset and gated slots all fault
    task automatic t_err;
        int e;
        logic [127:0] en;
        logic [1:0] w;
        logic [11:0] off;
        for (int i = 0; i < 6; i++) begin
            slot_clk_gate[55] <= (i != 5);
            xact(bad_addr[i], e, en, w, off);
            `check_eq("err cycles", 2, e)
            `check_eq("err enable", 128'h0, en)
        end
        slot_clk_gate[55] <= 1'b1;
    endtask : t_err
    // reset in mid-access drops the enable and a held request is not taken
    task t_reset_mid;
        @(posedge mclk);
        slow <= 1'b1;
        xbar_sel <= 1'b1;
        xbar_addr <= 32'h4003_7004;
        @(negedge mclk);
        @(negedge mclk);
        `check_eq("mid en", 128'h1 << 55, slot_enable)
        @(posedge mclk);
        arst_n <= 1'b0;
        repeat (2) begin
            @(negedge mclk);
            `check_eq("mid rst", 130'h0, {slot_enable, xbar_ready, xbar_err})
        end
        @(posedge mclk);
        arst_n <= 1'b1;
        xbar_sel <= 1'b0;
        slow <= 1'b0;
        repeat (2) begin
            @(negedge mclk);
            `check_eq("after rst", 130'h0, {slot_enable, xbar_ready, xbar_err})
        end
    endtask : t_reset_mid
    task t_gpio;
        @(posedge mclk);
        core_gpio_sel <= 1'b1;
        @(negedge mclk);
        `check_eq("gpio on", 1'b1, core_gpio_enable)
        @(posedge mclk);
        slot_clk_gate[15] <= 1'b0;
        @(negedge mclk);
        `check_eq("gpio gated", 1'b0, core_gpio_enable)
        @(posedge mclk);
        slot_clk_gate[15] <= 1'b1;
        core_gpio_sel <= 1'b0;
    endtask : t_gpio
    task automatic t_priv;
        logic [31:0] pa[6] = '{32'he000_e010, NESTED_IRQ_CONTROLLER_LO, SCB_LO,
            CORE_ROM_SPACE_LO, PRIV_BASE, NESTED_IRQ_CONTROLLER_LO};
        logic [4:0] ex[6] = '{5'h10, 5'h18, 5'h14, 5'h02, 5'h01, 5'h01};
        logic [4:0] got;
        for (int i = 0; i < 6; i++) begin
            @(posedge mclk);
            priv_sel <= 1'b1;
            priv_addr <= pa[i];
            priv_from_core <= (i != 5);
            @(negedge mclk);
            got = {priv_system_control_space_sel, priv_nested_irq_controller_sel, priv_scb_sel,
                priv_core_rom_space_sel, priv_err};
            `check_eq("priv", ex[i], got)
        end
        @(posedge mclk);
        priv_sel <= 1'b0;
    endtask : t_priv
    // ----------------------------------------
    // run control
    // ----------------------------------------
    task stop_test;
        if (bad_count == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test
    // watchdog sized well past the hundred-odd cycles the run needs
    initial begin
        repeat (5000) @(posedge mclk);
        bad_count++;
        stop_test;
    end
    initial begin
        {mclk, arst_n, xbar_sel, core_gpio_sel, priv_sel, slow} = '0;
        {xbar_from_core, priv_from_core} = 2'h3;
        {xbar_addr, priv_addr} = '0;
        slot_clk_gate = '1;
        t_reset;
        t_window;
        t_good;
        t_err;
        t_reset_mid;
        t_gpio;
        t_priv;
        stop_test;
    end
endmodule : tb_top
